/* File: core/uim_pkg.sv */
// Constants for the usart interrupt-mask bank with SPI clock settings.
// Assumes a 20 MHz peripheral clock and registers reached over APB.
// Summary of operation
// - In SPI master or slave mode the serial clock rests at the level chosen by spi_clock_idle_level.
// - The serial clock pin is driven only with serial_clock_drive_select set and the clock selection field not external.
// - With transmit gating off a written character starts once the holding register took it and the shifter is idle.
// - In SPI modes with transmit gating on a written character starts only while no received character waits.
// - Writing interrupt_enable_set sets each mask bit written as one; reads return zero.
// - Writing interrupt_enable_clear clears each mask bit written as one; it is write-only.
// - interrupt_enable_view reads one for each enabled interrupt source and zero otherwise.
// - Outside SPI modes the enables sit at bits 0 to 9, 11, 12 and 19.
// - In SPI modes bit 10 enables underrun and break, framing, parity, timeout, cts enables vanish.
// - The SPI layout applies only when the mode field selects SPI master or SPI slave.
// - Count-end and buffer empty or full enables work in every operating mode.
// - The received-character flag sets on a complete character and clears on a holding read.
// - The SPI underrun flag stays set until status_reset_command or its own status bit is written as one.
package uim_pkg;
    localparam logic [31:0] CTRL_ADDR = 32'h40024000;
    localparam logic [31:0] MODE_ADDR = 32'h40024004;
    localparam logic [31:0] IES_ADDR  = 32'h40024008;
    localparam logic [31:0] IEC_ADDR  = 32'h4002400c;
    localparam logic [31:0] IEV_ADDR  = 32'h40024010;
    localparam logic [31:0] STAT_ADDR = 32'h40024014;
    localparam logic [31:0] RHR_ADDR  = 32'h40024018;
    localparam logic [31:0] THR_ADDR  = 32'h4002401c;

    localparam int B_RXCHR   = 0;
    localparam int B_TXFREE  = 1;
    localparam int B_BRK     = 2;
    localparam int B_RXCEND  = 3;
    localparam int B_TXCEND  = 4;
    localparam int B_OVRUN   = 5;
    localparam int B_FRAME   = 6;
    localparam int B_PARITY  = 7;
    localparam int B_TIMEOUT = 8;
    localparam int B_DRAINED = 9;
    localparam int B_UNDRUN  = 10;
    localparam int B_TXBEMP  = 11;
    localparam int B_RXBFUL  = 12;
    localparam int B_CTSCHG  = 19;

    localparam logic [31:0] NORMAL_LAYOUT = 32'h00081bff;
    localparam logic [31:0] SPI_LAYOUT    = 32'h00001e3b;
    localparam logic [31:0] STICKY_BITS   = 32'h000805e4;
    localparam logic [31:0] STRST_CLEARS  = 32'h000004e4;
    localparam logic [31:0] MODE_WMASK    = 32'h001501ff;
    localparam logic [31:0] MODE_RESET    = 32'h00000000;
    localparam logic [31:0] MASK_RESET    = 32'h00000000;

    localparam int STRST_BIT     = 8;
    localparam int MODE_LSB      = 0;
    localparam int MODE_W        = 4;
    localparam int CLKS_LSB      = 4;
    localparam int CLKS_W        = 2;
    localparam int IDLE_LVL_BIT  = 16;
    localparam int DRIVE_SEL_BIT = 18;
    localparam int GATING_BIT    = 20;

    localparam logic [3:0] MODE_SPI_MASTER = 4'he;
    localparam logic [3:0] MODE_SPI_SLAVE  = 4'hf;
    localparam logic [1:0] CLKS_DIV        = 2'h1;
    localparam logic [1:0] CLKS_EXT        = 2'h3;

    localparam int CLK_DIV_DEFAULT = 8;
    localparam int CHAR_BITS       = 8;

    typedef enum logic {TX_IDLE, TX_SHIFT} uim_tx_state_t;
endpackage : uim_pkg

/* File: core/uim_link_if.sv */
// Carries the sampled serial clock from the synchroniser to the core.
// Assumes both ends run on the peripheral clock.
interface uim_link_if;
    logic level;
    logic rise;
    logic fall;

    modport sync_side (output level, output rise, output fall);
    modport core_side (input level, input rise, input fall);
endinterface : uim_link_if

/* File: core/uim_link_sync.sv */
// Two-stage synchroniser and edge finder for the external serial clock.
// Assumes the link clock is slow against core_clk_i (400 ns against 50 ns).
module uim_link_sync (
    // Clock and reset
    input  wire logic     core_clk_i,
    input  wire logic     rst_i,
    // Raw pin
    input  wire logic     link_clk_i,
    // Sampled view
    uim_link_if.sync_side link
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } uim_sync_state_t;

    uim_sync_state_t state_ff;
    uim_sync_state_t nxt_state;

    always_comb begin
        nxt_state      = state_ff;
        nxt_state.meta = link_clk_i;
        nxt_state.sync = state_ff.meta;
        nxt_state.last = state_ff.sync;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Edges are taken between the second and third stage, never from meta
    assign link.level = state_ff.sync;
    assign link.rise  = state_ff.sync & ~state_ff.last;
    assign link.fall  = ~state_ff.sync & state_ff.last;
endmodule : uim_link_sync

/* File: core/uim_core.sv */
// Interrupt mask bank, status flags and SPI clock and transmit gating of the usart.
// Assumes an APB master on core_clk_i and receiver events on the same clock.
//
// The implementer's own choice: the APB slave port.
module uim_core #(
    parameter int CLK_DIV = uim_pkg::CLK_DIV_DEFAULT
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Receiver and buffer events
    input  wire logic        rx_char_valid_i,
    input  wire logic [7:0]  rx_char_i,
    input  wire logic        rx_count_end_i,
    input  wire logic        tx_count_end_i,
    input  wire logic        tx_bufs_empty_i,
    input  wire logic        rx_bufs_full_i,
    input  wire logic        break_seen_i,
    input  wire logic        frame_err_i,
    input  wire logic        parity_err_i,
    input  wire logic        timeout_i,
    input  wire logic        cts_change_i,
    // Serial line
    input  wire logic        link_clk_i,
    output logic             spi_clock_line_o,
    output logic             spi_clock_line_oe_n_o,
    output logic             txd_o,
    // Interrupt
    output logic             irq_o
);
    localparam int DIV_W  = $clog2(CLK_DIV);
    localparam int HALF_W = $clog2(2 * uim_pkg::CHAR_BITS);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(CLK_DIV - 1);
    localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(2 * uim_pkg::CHAR_BITS - 1);

    if (CLK_DIV < 2) begin : g_bad_div
        $error("CLK_DIV must be at least 2");
    end

    typedef struct packed {
        logic [31:0]                   mask;
        logic [31:0]                   mode;
        logic [31:0]                   sticky;
        logic                          rx_flag;
        logic [7:0]                    rx_data;
        logic                          hold_full;
        logic [7:0]                    hold_data;
        logic [7:0]                    sh_data;
        uim_pkg::uim_tx_state_t        tx_state;
        logic [HALF_W-1:0]             half_cnt;
        logic [DIV_W-1:0]              div_cnt;
        logic                          sclk;
        logic                          txd;
        logic [31:0]                   rdata;
        logic                          perr;
    } uim_core_state_t;

    uim_core_state_t state_ff;
    uim_core_state_t nxt_state;

    uim_link_if link ();

    uim_link_sync u_link_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .link_clk_i (link_clk_i),
        .link       (link)
    );

    function automatic logic is_spi(input logic [31:0] mode);
        logic [3:0] m;
        m = mode[uim_pkg::MODE_LSB +: uim_pkg::MODE_W];
        return (m == uim_pkg::MODE_SPI_MASTER) || (m == uim_pkg::MODE_SPI_SLAVE);
    endfunction : is_spi

    function automatic logic [31:0] layout_of(input logic [31:0] mode);
        return is_spi(mode) ? uim_pkg::SPI_LAYOUT : uim_pkg::NORMAL_LAYOUT;
    endfunction : layout_of

    function automatic logic addr_known(input logic [31:0] a);
        return a inside {uim_pkg::CTRL_ADDR, uim_pkg::MODE_ADDR, uim_pkg::IES_ADDR,
                         uim_pkg::IEC_ADDR, uim_pkg::IEV_ADDR, uim_pkg::STAT_ADDR,
                         uim_pkg::RHR_ADDR, uim_pkg::THR_ADDR};
    endfunction : addr_known

    logic        setup;
    logic        acc_wr;
    logic        acc_rd;
    logic [31:0] view;
    logic [31:0] live;
    logic [31:0] stat_view;
    logic [3:0]  mode_f;
    logic [1:0]  clks_f;
    logic        idle_lvl;
    logic        ext_clk;
    logic        tick;
    logic        gate_ok;
    logic        rd_rhr;

    assign setup    = psel_i & ~penable_i;
    assign acc_wr   = psel_i & penable_i & pwrite_i & ~state_ff.perr;
    assign acc_rd   = psel_i & penable_i & ~pwrite_i & ~state_ff.perr;
    assign rd_rhr   = acc_rd & (paddr_i == uim_pkg::RHR_ADDR);
    assign mode_f   = state_ff.mode[uim_pkg::MODE_LSB +: uim_pkg::MODE_W];
    assign clks_f   = state_ff.mode[uim_pkg::CLKS_LSB +: uim_pkg::CLKS_W];
    assign idle_lvl = state_ff.mode[uim_pkg::IDLE_LVL_BIT];
    assign view     = state_ff.mask & layout_of(state_ff.mode);
    assign ext_clk  = (clks_f == uim_pkg::CLKS_EXT) || (mode_f == uim_pkg::MODE_SPI_SLAVE);

    // Gating only means something in SPI modes, where a reply waits on a read
    assign gate_ok  = ~(is_spi(state_ff.mode) & state_ff.mode[uim_pkg::GATING_BIT])
                      | ~state_ff.rx_flag;

    always_comb begin
        if (ext_clk) begin
            tick = link.rise | link.fall;
        end else if (clks_f == uim_pkg::CLKS_DIV) begin
            tick = (state_ff.div_cnt == DIV_LAST);
        end else begin
            tick = 1'b1;
        end
    end

    always_comb begin
        live                     = '0;
        live[uim_pkg::B_RXCHR]   = state_ff.rx_flag;
        live[uim_pkg::B_TXFREE]  = ~state_ff.hold_full;
        live[uim_pkg::B_RXCEND]  = rx_count_end_i;
        live[uim_pkg::B_TXCEND]  = tx_count_end_i;
        live[uim_pkg::B_DRAINED] = ~state_ff.hold_full & (state_ff.tx_state == uim_pkg::TX_IDLE);
        live[uim_pkg::B_TXBEMP]  = tx_bufs_empty_i;
        live[uim_pkg::B_RXBFUL]  = rx_bufs_full_i;
    end

    assign stat_view = state_ff.sticky | live;

    always_comb begin
        nxt_state = state_ff;

        // Read data and error are latched in the setup cycle; no wait states
        if (setup) begin
            nxt_state.perr = ~addr_known(paddr_i);
            unique case (paddr_i)
                uim_pkg::MODE_ADDR: nxt_state.rdata = state_ff.mode;
                uim_pkg::IEV_ADDR:  nxt_state.rdata = view;
                uim_pkg::STAT_ADDR: nxt_state.rdata = stat_view;
                uim_pkg::RHR_ADDR:  nxt_state.rdata = {24'h000000, state_ff.rx_data};
                default:            nxt_state.rdata = 32'h00000000;
            endcase
        end

        // Software clears come first so that hardware sets below win
        if (acc_wr) begin
            unique case (paddr_i)
                uim_pkg::CTRL_ADDR: begin
                    if (pwdata_i[uim_pkg::STRST_BIT]) begin
                        nxt_state.sticky = state_ff.sticky & ~uim_pkg::STRST_CLEARS;
                    end
                end
                uim_pkg::MODE_ADDR: begin
                    nxt_state.mode = pwdata_i & uim_pkg::MODE_WMASK;
                end
                uim_pkg::IES_ADDR: begin
                    nxt_state.mask = state_ff.mask | (pwdata_i & layout_of(state_ff.mode));
                end
                uim_pkg::IEC_ADDR: begin
                    nxt_state.mask = state_ff.mask & ~(pwdata_i & layout_of(state_ff.mode));
                end
                uim_pkg::STAT_ADDR: begin
                    nxt_state.sticky = state_ff.sticky & ~(pwdata_i & uim_pkg::STICKY_BITS);
                end
                uim_pkg::THR_ADDR: begin
                    // A write while the holding register is still full is dropped
                    if (!state_ff.hold_full) begin
                        nxt_state.hold_full = 1'b1;
                        nxt_state.hold_data = pwdata_i[7:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (rd_rhr) begin
            nxt_state.rx_flag = 1'b0;
        end
        if (acc_rd && (paddr_i == uim_pkg::STAT_ADDR)) begin
            nxt_state.sticky[uim_pkg::B_CTSCHG] = 1'b0;
        end

        if (rx_char_valid_i) begin
            if (state_ff.rx_flag && !rd_rhr) begin
                nxt_state.sticky[uim_pkg::B_OVRUN] = 1'b1;
            end
            nxt_state.rx_flag = 1'b1;
            nxt_state.rx_data = rx_char_i;
        end
        if (break_seen_i) begin
            nxt_state.sticky[uim_pkg::B_BRK] = 1'b1;
        end
        if (frame_err_i) begin
            nxt_state.sticky[uim_pkg::B_FRAME] = 1'b1;
        end
        if (parity_err_i) begin
            nxt_state.sticky[uim_pkg::B_PARITY] = 1'b1;
        end
        if (timeout_i) begin
            nxt_state.sticky[uim_pkg::B_TIMEOUT] = 1'b1;
        end
        if (cts_change_i) begin
            nxt_state.sticky[uim_pkg::B_CTSCHG] = 1'b1;
        end

        if (clks_f == uim_pkg::CLKS_DIV) begin
            nxt_state.div_cnt = (state_ff.div_cnt == DIV_LAST) ? '0 : state_ff.div_cnt + 1'b1;
        end else begin
            nxt_state.div_cnt = '0;
        end

        unique case (state_ff.tx_state)
            uim_pkg::TX_IDLE: begin
                if (state_ff.hold_full && gate_ok) begin
                    nxt_state.tx_state  = uim_pkg::TX_SHIFT;
                    nxt_state.hold_full = 1'b0;
                    nxt_state.sh_data   = state_ff.hold_data;
                    nxt_state.txd       = state_ff.hold_data[7];
                    nxt_state.half_cnt  = '0;
                end else if (tick && ext_clk && !state_ff.hold_full
                             && mode_f == uim_pkg::MODE_SPI_SLAVE) begin
                    // Peer clocks us with nothing to send
                    nxt_state.sticky[uim_pkg::B_UNDRUN] = 1'b1;
                end
            end
            uim_pkg::TX_SHIFT: begin
                if (tick) begin
                    nxt_state.half_cnt = state_ff.half_cnt + 1'b1;
                    // Data changes as the trailing half of each bit ends
                    if (state_ff.half_cnt[0]) begin
                        nxt_state.sh_data = {state_ff.sh_data[6:0], 1'b0};
                        nxt_state.txd     = state_ff.sh_data[6];
                    end
                    if (state_ff.half_cnt == HALF_LAST) begin
                        nxt_state.tx_state = uim_pkg::TX_IDLE;
                    end
                end
            end
        endcase

        // Line sits at the idle level except in the second half of each bit while shifting
        nxt_state.sclk = nxt_state.mode[uim_pkg::IDLE_LVL_BIT]
                         ^ ((nxt_state.tx_state == uim_pkg::TX_SHIFT)
                            & nxt_state.half_cnt[0]);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff          <= '0;
            state_ff.mode     <= uim_pkg::MODE_RESET;
            state_ff.mask     <= uim_pkg::MASK_RESET;
            state_ff.tx_state <= uim_pkg::TX_IDLE;
            state_ff.txd      <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata_o  = state_ff.rdata;
    assign pready_o  = 1'b1;
    assign pslverr_o = state_ff.perr & psel_i & penable_i;
    assign txd_o     = state_ff.txd;
    assign spi_clock_line_o = state_ff.sclk;
    assign spi_clock_line_oe_n_o = ~(state_ff.mode[uim_pkg::DRIVE_SEL_BIT]
                                     & (clks_f != uim_pkg::CLKS_EXT));
    assign irq_o     = |(stat_view & view);

    a_idle_level:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_ff.tx_state == uim_pkg::TX_IDLE) |-> (spi_clock_line_o == idle_lvl))
        else $error("serial clock not at idle level");

    a_pin_drive:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        spi_clock_line_oe_n_o == !(state_ff.mode[uim_pkg::DRIVE_SEL_BIT]
                                   && clks_f != uim_pkg::CLKS_EXT))
        else $error("serial clock pin drive wrong");

    a_tx_start:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_ff.tx_state == uim_pkg::TX_IDLE && state_ff.hold_full
         && !state_ff.mode[uim_pkg::GATING_BIT])
        |=> (state_ff.tx_state == uim_pkg::TX_SHIFT) && !state_ff.hold_full)
        else $error("character did not start");

    a_tx_gated:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (is_spi(state_ff.mode) && state_ff.mode[uim_pkg::GATING_BIT]
         && state_ff.rx_flag && state_ff.tx_state == uim_pkg::TX_IDLE)
        |=> state_ff.tx_state == uim_pkg::TX_IDLE)
        else $error("gated character started");

    a_enable_set:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (acc_wr && paddr_i == uim_pkg::IES_ADDR && pwdata_i[uim_pkg::B_OVRUN])
        |=> view[uim_pkg::B_OVRUN])
        else $error("enable set lost");

    a_enable_clear:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (acc_wr && paddr_i == uim_pkg::IEC_ADDR && pwdata_i[uim_pkg::B_TXFREE])
        |=> !view[uim_pkg::B_TXFREE])
        else $error("enable clear lost");

    a_view_read:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (setup && !pwrite_i && paddr_i == uim_pkg::IEV_ADDR) |=> prdata_o == $past(view))
        else $error("mask view read wrong");

    a_normal_layout:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        !is_spi(state_ff.mode) |-> (view & ~uim_pkg::NORMAL_LAYOUT) == 32'h00000000)
        else $error("normal layout bit out of place");

    a_spi_layout:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        is_spi(state_ff.mode) |-> !view[uim_pkg::B_BRK] && !view[uim_pkg::B_CTSCHG]
                                  && (view & ~uim_pkg::SPI_LAYOUT) == 32'h00000000)
        else $error("spi layout bit out of place");

    a_count_enables:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (acc_wr && paddr_i == uim_pkg::IES_ADDR && pwdata_i[uim_pkg::B_RXCEND])
        |=> view[uim_pkg::B_RXCEND])
        else $error("count-end enable lost");

    a_rx_flag:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        rx_char_valid_i |=> stat_view[uim_pkg::B_RXCHR] && state_ff.rx_data == $past(rx_char_i))
        else $error("received character flag not set");

    a_underrun_hold:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_ff.sticky[uim_pkg::B_UNDRUN]
         && !(acc_wr && paddr_i == uim_pkg::CTRL_ADDR && pwdata_i[uim_pkg::STRST_BIT])
         && !(acc_wr && paddr_i == uim_pkg::STAT_ADDR && pwdata_i[uim_pkg::B_UNDRUN]))
        |=> state_ff.sticky[uim_pkg::B_UNDRUN])
        else $error("underrun flag dropped");

    a_irq_raise:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rx_char_valid_i && view[uim_pkg::B_RXCHR] && !rd_rhr) |=> irq_o)
        else $error("interrupt not raised");
endmodule : uim_core

/* File: tb/uim_peer.sv */
// Serial peer model: makes the link clock only within frames, 400 ns period.
// Assumes the bench calls burst while the block expects link edges.
module uim_peer (
    // Link clock towards the block
    output logic link_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial link_clk_o = 1'b0;
    // Stands still at its idle level between frames; the odd offset keeps phase unrelated
    task automatic burst(input int cycles);
        #37;
        repeat (cycles) begin
            #200 link_clk_o = 1'b1;
            #200 link_clk_o = 1'b0;
        end
    endtask : burst
endmodule : uim_peer

/* File: tb/usart_irq_mask_spi_cfg_test.sv */
// Bench for the usart interrupt mask bank: APB register tasks and directed scenarios.
// Assumes uim_core with a small divider and the uim_peer link clock model.
module usart_irq_mask_spi_cfg_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, psel, pen, pwr, pready, pslverr, err, rxv, link;
    logic        sck, sck_oe_n, txd, irq, last;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0]  rxc, shifted;
    logic [8:0]  ev;
    int          miscompares, cmp_count, n;
    int          evb[9] = '{3, 4, 11, 12, 2, 6, 7, 8, 19};

    uim_core #(.CLK_DIV(2)) u_dut (
        .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .rx_char_valid_i(rxv), .rx_char_i(rxc),
        .rx_count_end_i(ev[0]), .tx_count_end_i(ev[1]), .tx_bufs_empty_i(ev[2]),
        .rx_bufs_full_i(ev[3]), .break_seen_i(ev[4]), .frame_err_i(ev[5]),
        .parity_err_i(ev[6]), .timeout_i(ev[7]), .cts_change_i(ev[8]),
        .link_clk_i(link), .spi_clock_line_o(sck), .spi_clock_line_oe_n_o(sck_oe_n),
        .txd_o(txd), .irq_o(irq));
    uim_peer u_peer (.link_clk_o(link));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd & m);
    endtask : rdc
    task automatic irqc(input logic e);
        @(posedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irqc
    task automatic rx_pulse(input logic [7:0] c);
        @(posedge clk);
        rxv <= 1'b1;
        rxc <= c;
        @(posedge clk);
        rxv <= 1'b0;
    endtask : rx_pulse

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #4ms;
        miscompares++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        {psel, pen, pwr, rxv} = 4'h0;
        {paddr, pwdata, rxc, ev} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc("view", uim_pkg::IEV_ADDR, '1, 32'h0);
        rdc("set reads", uim_pkg::IES_ADDR, '1, 32'h0);
        irqc(1'b0);
        apb(1'b0, 32'h40024020, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        // One source at a time, so only its own bit can raise the request
        for (int i = 0; i < 9; i++) begin
            wr(uim_pkg::IES_ADDR, 32'h1 << evb[i]);
            rdc("view", uim_pkg::IEV_ADDR, '1, 32'h1 << evb[i]);
            @(posedge clk);
            ev[i] <= 1'b1;
            rdc("status", uim_pkg::STAT_ADDR, 32'h1 << evb[i], 32'h1 << evb[i]);
            irqc(1'b1);
            @(posedge clk);
            ev[i] <= 1'b0;
            wr(uim_pkg::STAT_ADDR, 32'h1 << evb[i]);
            irqc(1'b0);
            wr(uim_pkg::IEC_ADDR, 32'h1 << evb[i]);
            rdc("view", uim_pkg::IEV_ADDR, '1, 32'h0);
        end
        wr(uim_pkg::IEV_ADDR, '1);
        rdc("view ro", uim_pkg::IEV_ADDR, '1, 32'h0);
        wr(uim_pkg::IES_ADDR, '1);
        rdc("view", uim_pkg::IEV_ADDR, '1, uim_pkg::NORMAL_LAYOUT);
        wr(uim_pkg::IEC_ADDR, 32'h00000021);
        rdc("view", uim_pkg::IEV_ADDR, '1, uim_pkg::NORMAL_LAYOUT & ~32'h21);
        wr(uim_pkg::MODE_ADDR, 32'h0000000e);
        wr(uim_pkg::IES_ADDR, '1);
        rdc("spi view", uim_pkg::IEV_ADDR, '1, uim_pkg::SPI_LAYOUT);
        wr(uim_pkg::MODE_ADDR, 32'h0000000d);
        rdc("view", uim_pkg::IEV_ADDR, '1, uim_pkg::NORMAL_LAYOUT);
        wr(uim_pkg::IEC_ADDR, '1);
        wr(uim_pkg::MODE_ADDR, 32'h0015000e);
        @(posedge clk);
        chk("idle high", 32'h1, {31'h0, sck});
        chk("drive", 32'h0, {31'h0, sck_oe_n});
        rx_pulse(8'ha5);
        wr(uim_pkg::THR_ADDR, 32'h3c);
        rdc("gated", uim_pkg::STAT_ADDR, 32'h2, 32'h0);
        rdc("rx char", uim_pkg::RHR_ADDR, 32'hff, 32'ha5);
        rdc("released", uim_pkg::STAT_ADDR, 32'h3, 32'h2);
        repeat (20) @(posedge clk);
        wr(uim_pkg::MODE_ADDR, 32'h0004000e);
        wr(uim_pkg::IES_ADDR, 32'h1);
        rx_pulse(8'h11);
        irqc(1'b1);
        wr(uim_pkg::THR_ADDR, 32'hc3);
        last = sck;
        chk("idle low", 32'h0, {31'h0, last});
        n = 0;
        for (int k = 0; k < 24; k++) begin
            @(posedge clk);
            if (sck !== last) begin
                n++;
            end
            // Data is stable while the line sits at its active level
            if (sck === 1'b1 && last === 1'b0) begin
                shifted = {shifted[6:0], txd};
            end
            last = sck;
        end
        chk("clock toggles", 32'd16, 32'(n));
        chk("txd byte", 32'hc3, {24'h0, shifted});
        rdc("ungated", uim_pkg::STAT_ADDR, 32'h203, 32'h203);
        rdc("rx char", uim_pkg::RHR_ADDR, 32'hff, 32'h11);
        wr(uim_pkg::MODE_ADDR, 32'h0004003e);
        @(posedge clk);
        chk("no drive ext", 32'h1, {31'h0, sck_oe_n});
        wr(uim_pkg::MODE_ADDR, 32'h0000000f);
        @(posedge clk);
        chk("no drive", 32'h1, {31'h0, sck_oe_n});
        wr(uim_pkg::IES_ADDR, 32'h400);
        u_peer.burst(1);
        repeat (5) @(posedge clk);
        rdc("underrun", uim_pkg::STAT_ADDR, 32'h400, 32'h400);
        irqc(1'b1);
        wr(uim_pkg::CTRL_ADDR, 32'h100);
        rdc("underrun", uim_pkg::STAT_ADDR, 32'h400, 32'h0);
        irqc(1'b0);
        wr(uim_pkg::THR_ADDR, 32'h5a);
        u_peer.burst(8);
        repeat (5) @(posedge clk);
        rdc("drained", uim_pkg::STAT_ADDR, 32'h602, 32'h202);
        end_of_test();
    end
endmodule : usart_irq_mask_spi_cfg_test
